// ---- hw/mpi_pkg.sv ----
// Purpose: Shared constants and carriers for the motion program interpreter
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Program storage and block parsing sit outside this block
package mpi_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned MPI_POS_DEPTH  = 2000;
  localparam int unsigned MPI_POS_AW     = 11;
  localparam int unsigned MPI_REG_COUNT  = 32;
  localparam int unsigned MPI_REG_AW     = 5;
  localparam int unsigned MPI_VAL_W      = 32;
  localparam int unsigned MPI_PROG_LIMIT = 100;

  // ****************************************
  // Ranges
  // ****************************************
  localparam logic [10:0] MPI_REG_MAX      = 11'h7CF;
  localparam logic [31:0] MPI_POS_MAX      = 32'h0262_59FF;
  localparam logic [31:0] MPI_POS_MIN      = 32'hFD9D_A601;
  localparam logic [9:0]  MPI_MAIN_MAX     = 10'h1F3;
  localparam logic [9:0]  MPI_PROG_MAX     = 10'h3E7;
  localparam logic [9:0]  MPI_MCODE_MAX    = 10'h3E7;
  localparam logic [9:0]  MPI_FIRST_BLOCK  = 10'h000;
  localparam logic [2:0]  MPI_OPT_MAX      = 3'h6;
  localparam logic [2:0]  MPI_OPT_HOST_MAX = 3'h4;
  localparam logic [6:0]  MPI_PROG_CNT_MAX = 7'h64;
  localparam logic [10:0] MPI_REG_RESET    = 11'h000;

  // ****************************************
  // Operand and command encodings
  // ****************************************
  typedef enum logic [1:0] {
    MPI_OP_LITERAL,
    MPI_OP_POS_ADDR,
    MPI_OP_REG_DIRECT,
    MPI_OP_REG_INDIRECT
  } mpi_op_kind_t;

  typedef enum logic [1:0] {
    MPI_COORD_VALUE,
    MPI_COORD_PLUS_LIMIT,
    MPI_COORD_MINUS_LIMIT
  } mpi_coord_kind_t;

  typedef enum logic [3:0] {
    MPI_CMD_DECLARE,
    MPI_CMD_POINT_TO_POINT_POSITIONING,
    MPI_CMD_VALUE_SUBSTITUTION,
    MPI_CMD_ARITHMETIC_OPERATION,
    MPI_CMD_MAIN_PROGRAM_END,
    MPI_CMD_SUBPROGRAM_END,
    MPI_CMD_POS_WRITE,
    MPI_CMD_OTHER
  } mpi_cmd_t;

  typedef enum logic [3:0] {
    MPI_LETTER_I, MPI_LETTER_J, MPI_LETTER_R, MPI_LETTER_F,
    MPI_LETTER_L, MPI_LETTER_N, MPI_LETTER_P, MPI_LETTER_OTHER
  } mpi_letter_t;

  typedef enum logic [3:0] {
    MPI_ERR_NONE, MPI_ERR_REG_RANGE, MPI_ERR_POS_RANGE, MPI_ERR_ADDR_RANGE,
    MPI_ERR_DECL_BLOCK, MPI_ERR_PROG_NUM, MPI_ERR_MCODE, MPI_ERR_OPT,
    MPI_ERR_PROG_COUNT, MPI_ERR_END_KIND
  } mpi_err_t;

  typedef struct packed {
    mpi_op_kind_t kind;
    logic [31:0]  value;
  } mpi_operand_t;

  typedef struct packed {
    logic            used;
    mpi_coord_kind_t ckind;
    mpi_operand_t    opnd;
  } mpi_axis_arg_t;

  typedef struct packed {
    mpi_cmd_t      cmd;
    logic [9:0]    block_num;
    logic [9:0]    prog_num;
    mpi_axis_arg_t x_arg;
    mpi_axis_arg_t y_arg;
    logic          m_used;
    mpi_operand_t  m_opnd;
    logic          opt_used;
    logic [2:0]    opt_num;
    logic [4:0]    dst_reg;
    logic [4:0]    src_a_reg;
    logic [4:0]    src_b_reg;
    logic          sub_not_add;
  } mpi_block_t;

  typedef struct packed {
    logic        x_move;
    logic        y_move;
    mpi_coord_kind_t x_kind;
    mpi_coord_kind_t y_kind;
    logic [31:0] x_target;
    logic [31:0] y_target;
    logic [7:0]  override;
  } mpi_move_t;

  function automatic logic pos_in_range(input logic [31:0] v);
    return ($signed(v) <= $signed(MPI_POS_MAX)) && ($signed(v) >= $signed(MPI_POS_MIN));
  endfunction

endpackage

// ---- hw/mpi_pos_mem.sv ----
// Purpose: Position data store shared by all tasks
// Assumes: One access per cycle, registered read data
// Notes:   Contents are not cleared at reset
`timescale 1ns/1ps
`default_nettype none
module mpi_pos_mem (
  // Clock
  input  wire logic        ref_clk,
  // Access
  input  wire logic        wr_en,
  input  wire logic [10:0] addr,
  input  wire logic [31:0] wr_data,
  output var  logic [31:0] rd_data
);
  import mpi_pkg::*;

  logic [31:0] mem [0:MPI_POS_DEPTH-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule
`default_nettype wire

// ---- hw/mpi_reg_file.sv ----
// Purpose: Indirect register file, one pool for all tasks
// Assumes: Writer has already range checked the value
// Notes:   Cleared by reset only; program start leaves it alone
`timescale 1ns/1ps
`default_nettype none
module mpi_reg_file (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [10:0] wr_data,
  // Read ports
  input  wire logic [4:0]  rd_a_idx,
  output logic      [10:0] rd_a_data,
  input  wire logic [4:0]  rd_b_idx,
  output logic      [10:0] rd_b_data
);
  import mpi_pkg::*;

  logic [10:0] regs_reg [0:MPI_REG_COUNT-1];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < MPI_REG_COUNT; i++) begin
      if (rst) begin
        regs_reg[i] <= MPI_REG_RESET;
      end else if (wr_en && (wr_idx == i[4:0])) begin
        regs_reg[i] <= wr_data;
      end
    end
  end

  assign rd_a_data = regs_reg[rd_a_idx];
  assign rd_b_data = regs_reg[rd_b_idx];

endmodule
`default_nettype wire

// ---- hw/mpi_interp.sv ----
// Purpose: Executes one decoded program block at a time
// Assumes: Blocks arrive decoded; axis generators report in-position
// Notes:   Declarations, positioning, substitution, arithmetic, position writes and ends run here
`timescale 1ns/1ps
`default_nettype none
module mpi_interp (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Block supply
  input  wire logic                 blk_valid,
  input  wire mpi_pkg::mpi_block_t  blk,
  output logic                      blk_ready,
  input  wire logic [6:0]           prog_count,
  // Position data write from program loader
  input  wire logic [31:0]          pos_wr_value,
  // Host data area
  input  wire logic [4:0]           host_opt_in,
  input  wire logic [7:0]           override_in,
  input  wire logic                 err_clear,
  // General inputs
  input  wire logic [1:0]           gen_in,
  // Letter decode
  input  wire logic [7:0]           letter_char,
  output logic                      letter_kind_valid,
  output mpi_pkg::mpi_letter_t      letter_kind,
  // Axis generators
  output mpi_pkg::mpi_move_t        move,
  output logic                      move_start,
  input  wire logic                 x_in_pos,
  input  wire logic                 y_in_pos,
  // Status
  output logic                      m_valid,
  output logic [9:0]                m_code,
  output logic                      is_subprogram,
  output logic                      prog_done,
  output logic                      err_flag,
  output mpi_pkg::mpi_err_t         err_code
);
  import mpi_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_REG_RD, S_MEM_WAIT, S_CHECK, S_OPT_WAIT, S_MOVE, S_HALT
  } mpi_state_t;

  mpi_state_t  state_reg;
  mpi_block_t  blk_reg;
  logic [1:0]  fetch_sel_reg;   // 0 x, 1 y, 2 m
  logic [31:0] x_val_reg, y_val_reg, m_val_reg;
  logic        sub_reg;
  logic        move_seen_reg;

  logic [10:0] reg_a, reg_b;
  logic        rf_wr;
  logic [10:0] rf_wdata;
  logic        mem_wr;
  logic [10:0] mem_addr;
  logic [31:0] mem_rd;
  mpi_err_t    err_now;
  logic        opt_bit;
  logic [11:0] arith;
  logic [4:0]  rd_a_idx;

  // ****************************************
  // Shared storage
  // ****************************************
  // One pool, no per-task banking
  mpi_reg_file u_regs (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .wr_en     (rf_wr),
    .wr_idx    (blk_reg.dst_reg),
    .wr_data   (rf_wdata),
    .rd_a_idx  (rd_a_idx),
    .rd_a_data (reg_a),
    .rd_b_idx  (blk_reg.src_b_reg),
    .rd_b_data (reg_b)
  );

  mpi_pos_mem u_pos (
    .ref_clk (ref_clk),
    .wr_en   (mem_wr),
    .addr    (mem_addr),
    .wr_data (pos_wr_value),
    .rd_data (mem_rd)
  );

  // ****************************************
  // Operand resolution
  // ****************************************
  function automatic mpi_operand_t sel_op(input mpi_block_t b, input logic [1:0] s);
    case (s)
      2'h0:    return b.x_arg.opnd;
      2'h1:    return b.y_arg.opnd;
      default: return b.m_opnd;
    endcase
  endfunction

  mpi_operand_t cur_op;
  logic [10:0]  cur_reg;
  assign cur_op = sel_op(blk_reg, fetch_sel_reg);
  assign cur_reg = (cur_op.kind == MPI_OP_REG_INDIRECT) ? reg_a : 11'h000;
  // Positioning operands name their own register; arithmetic reads its source
  assign rd_a_idx = (blk_reg.cmd == MPI_CMD_POINT_TO_POINT_POSITIONING) ?
                    cur_op.value[4:0] : blk_reg.src_a_reg;

  always_comb begin
    mem_addr = 11'h000;
    if (cur_op.kind == MPI_OP_REG_INDIRECT) begin
      mem_addr = cur_reg;
    end else begin
      mem_addr = cur_op.value[10:0];
    end
  end

  assign mem_wr = (state_reg == S_CHECK) && (blk_reg.cmd == MPI_CMD_POS_WRITE) &&
                  (err_now == MPI_ERR_NONE);

  always_comb begin
    arith = blk_reg.sub_not_add ? ({1'b0, reg_a} - {1'b0, reg_b}) : ({1'b0, reg_a} + {1'b0, reg_b});
    if (blk_reg.cmd == MPI_CMD_VALUE_SUBSTITUTION) begin
      // Any high bit folds into the overrange flag so large values cannot wrap
      arith = {|blk_reg.x_arg.opnd.value[31:11], blk_reg.x_arg.opnd.value[10:0]};
    end
    rf_wdata = arith[10:0];
  end

  assign rf_wr = (state_reg == S_CHECK) && (err_now == MPI_ERR_NONE) &&
                 ((blk_reg.cmd == MPI_CMD_ARITHMETIC_OPERATION) ||
                  (blk_reg.cmd == MPI_CMD_VALUE_SUBSTITUTION));

  // ****************************************
  // Error checks
  // ****************************************
  always_comb begin
    err_now = MPI_ERR_NONE;
    case (blk_reg.cmd)
      MPI_CMD_DECLARE: begin
        if (blk_reg.block_num != MPI_FIRST_BLOCK) err_now = MPI_ERR_DECL_BLOCK;
        else if (blk_reg.prog_num > MPI_PROG_MAX) err_now = MPI_ERR_PROG_NUM;
        else if (prog_count > MPI_PROG_CNT_MAX) err_now = MPI_ERR_PROG_COUNT;
      end
      MPI_CMD_ARITHMETIC_OPERATION, MPI_CMD_VALUE_SUBSTITUTION: begin
        if (arith > {1'b0, MPI_REG_MAX} || arith[11]) err_now = MPI_ERR_REG_RANGE;
      end
      MPI_CMD_POS_WRITE: begin
        if (!pos_in_range(pos_wr_value)) err_now = MPI_ERR_POS_RANGE;
        else if (blk_reg.x_arg.opnd.value > {21'h0, MPI_REG_MAX}) err_now = MPI_ERR_ADDR_RANGE;
      end
      MPI_CMD_POINT_TO_POINT_POSITIONING: begin
        if (blk_reg.x_arg.used && !pos_in_range(x_val_reg)) err_now = MPI_ERR_POS_RANGE;
        else if (blk_reg.y_arg.used && !pos_in_range(y_val_reg)) err_now = MPI_ERR_POS_RANGE;
        else if (blk_reg.m_used && m_val_reg > {22'h0, MPI_MCODE_MAX}) err_now = MPI_ERR_MCODE;
        else if (blk_reg.opt_used && blk_reg.opt_num > MPI_OPT_MAX) err_now = MPI_ERR_OPT;
      end
      MPI_CMD_MAIN_PROGRAM_END: if (sub_reg) err_now = MPI_ERR_END_KIND;
      MPI_CMD_SUBPROGRAM_END:   if (!sub_reg) err_now = MPI_ERR_END_KIND;
      default: err_now = MPI_ERR_NONE;
    endcase
  end

  // Optional inputs: low five from host, top two from general inputs
  assign opt_bit = (blk_reg.opt_num <= MPI_OPT_HOST_MAX) ? host_opt_in[blk_reg.opt_num] :
                   gen_in[blk_reg.opt_num[0] ? 1'b0 : 1'b1];

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      blk_reg       <= '0;
      fetch_sel_reg <= 2'h0;
      x_val_reg     <= 32'h0000_0000;
      y_val_reg     <= 32'h0000_0000;
      m_val_reg     <= 32'h0000_0000;
    end else begin
      case (state_reg)
        S_IDLE: if (blk_valid) begin
          blk_reg       <= blk;
          fetch_sel_reg <= 2'h0;
          state_reg     <= S_REG_RD;
        end
        S_REG_RD: begin
          if (blk_reg.cmd != MPI_CMD_POINT_TO_POINT_POSITIONING) begin
            state_reg <= S_CHECK;
          end else if (cur_op.kind == MPI_OP_POS_ADDR || cur_op.kind == MPI_OP_REG_INDIRECT) begin
            state_reg <= S_MEM_WAIT;
          end else begin
            case (fetch_sel_reg)
              2'h0:    x_val_reg <= (cur_op.kind == MPI_OP_REG_DIRECT) ? {21'h0, reg_a} : cur_op.value;
              2'h1:    y_val_reg <= (cur_op.kind == MPI_OP_REG_DIRECT) ? {21'h0, reg_a} : cur_op.value;
              default: m_val_reg <= (cur_op.kind == MPI_OP_REG_DIRECT) ? {21'h0, reg_a} : cur_op.value;
            endcase
            fetch_sel_reg <= fetch_sel_reg + 2'h1;
            if (fetch_sel_reg == 2'h2) state_reg <= S_CHECK;
          end
        end
        S_MEM_WAIT: begin
          case (fetch_sel_reg)
            2'h0:    x_val_reg <= mem_rd;
            2'h1:    y_val_reg <= mem_rd;
            default: m_val_reg <= mem_rd;
          endcase
          fetch_sel_reg <= fetch_sel_reg + 2'h1;
          state_reg     <= (fetch_sel_reg == 2'h2) ? S_CHECK : S_REG_RD;
        end
        S_CHECK: begin
          if (err_now != MPI_ERR_NONE) state_reg <= S_HALT;
          else if (blk_reg.cmd == MPI_CMD_POINT_TO_POINT_POSITIONING) state_reg <= S_OPT_WAIT;
          else state_reg <= S_IDLE;
        end
        S_OPT_WAIT: if (!blk_reg.opt_used || opt_bit) state_reg <= S_MOVE;
        S_MOVE: if (move_seen_reg && (!move.x_move || x_in_pos) && (!move.y_move || y_in_pos))
          state_reg <= S_IDLE;
        S_HALT: if (err_clear) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Axis command
  // ****************************************
  // Override latched here only, so speed stays fixed through the move
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      move          <= '0;
      move_start    <= 1'b0;
      move_seen_reg <= 1'b0;
    end else begin
      move_start <= 1'b0;
      if (state_reg == S_OPT_WAIT && (!blk_reg.opt_used || opt_bit)) begin
        move.x_move   <= blk_reg.x_arg.used;
        move.y_move   <= blk_reg.y_arg.used;
        move.x_kind   <= blk_reg.x_arg.ckind;
        move.y_kind   <= blk_reg.y_arg.ckind;
        move.x_target <= x_val_reg;
        move.y_target <= y_val_reg;
        move.override <= override_in;
        move_start    <= 1'b1;
        move_seen_reg <= 1'b0;
      end else if (state_reg == S_MOVE) begin
        move_seen_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_flag      <= 1'b0;
      err_code      <= MPI_ERR_NONE;
      sub_reg       <= 1'b0;
      is_subprogram <= 1'b0;
      prog_done     <= 1'b0;
      m_valid       <= 1'b0;
      m_code        <= 10'h000;
      blk_ready     <= 1'b0;
    end else begin
      prog_done <= 1'b0;
      m_valid   <= 1'b0;
      blk_ready <= (state_reg == S_IDLE) && !blk_valid;
      if (state_reg == S_CHECK && err_now != MPI_ERR_NONE) begin
        err_flag <= 1'b1;
        err_code <= err_now;
      end else if (err_clear) begin
        err_flag <= 1'b0;
        err_code <= MPI_ERR_NONE;
      end
      if (state_reg == S_CHECK && err_now == MPI_ERR_NONE) begin
        if (blk_reg.cmd == MPI_CMD_DECLARE) begin
          sub_reg       <= blk_reg.prog_num > MPI_MAIN_MAX;
          is_subprogram <= blk_reg.prog_num > MPI_MAIN_MAX;
        end
        if (blk_reg.cmd == MPI_CMD_MAIN_PROGRAM_END || blk_reg.cmd == MPI_CMD_SUBPROGRAM_END)
          prog_done <= 1'b1;
        if (blk_reg.cmd == MPI_CMD_POINT_TO_POINT_POSITIONING && blk_reg.m_used) begin
          m_valid <= 1'b1;
          m_code  <= m_val_reg[9:0];
        end
      end
    end
  end

  // ****************************************
  // Letter decode
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      letter_kind       <= MPI_LETTER_OTHER;
      letter_kind_valid <= 1'b0;
    end else begin
      letter_kind_valid <= 1'b1;
      case (letter_char)
        8'h49:   letter_kind <= MPI_LETTER_I;
        8'h4A:   letter_kind <= MPI_LETTER_J;
        8'h52:   letter_kind <= MPI_LETTER_R;
        8'h46:   letter_kind <= MPI_LETTER_F;
        8'h4C:   letter_kind <= MPI_LETTER_L;
        8'h4E:   letter_kind <= MPI_LETTER_N;
        8'h50:   letter_kind <= MPI_LETTER_P;
        default: letter_kind <= MPI_LETTER_OTHER;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_ERR_HALTS: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_CHECK && err_now != MPI_ERR_NONE) |=> (err_flag && state_reg == S_HALT))
    else $error("error did not halt");
  AST_REG_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
    rf_wr |-> rf_wdata <= MPI_REG_MAX)
    else $error("register overrange written");
  AST_OPT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_OPT_WAIT && blk_reg.opt_used && !opt_bit) |=> !move_start)
    else $error("move started without option");
  AST_INPOS: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_MOVE && move.x_move && !x_in_pos) |=> state_reg != S_IDLE)
    else $error("left move before in-position");
  AST_OVR: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_MOVE && $past(state_reg) == S_MOVE) |-> $stable(move.override))
    else $error("override changed in move");
  AST_DECL: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_CHECK && blk_reg.cmd == MPI_CMD_DECLARE && blk_reg.block_num != 10'h000)
    |=> err_code == MPI_ERR_DECL_BLOCK)
    else $error("late declaration accepted");
  AST_START: assert property (@(posedge ref_clk) disable iff (rst)
    move_start |-> ##1 state_reg == S_MOVE)
    else $error("start without move state");
  AST_RESET_REG: assert property (@(posedge ref_clk)
    $past(rst) |-> reg_b == 11'h000 || $past(rf_wr))
    else $error("register not cleared");

endmodule
`default_nettype wire

// ---- tb/mpi_axis_model.sv ----
// Purpose: Behavioural X/Y axis generators facing the interpreter
// Assumes: A start drops in-position on moved axes for DELAY cycles
// Notes:   Axes not named in a move stay in position
`timescale 1ns/1ps
`default_nettype none
module mpi_axis_model #(
  parameter int DELAY = 6
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Move request
  input  wire logic               move_start,
  input  wire mpi_pkg::mpi_move_t move,
  // Completion
  output logic                    x_in_pos,
  output logic                    y_in_pos
);
  import mpi_pkg::*;
  int cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg  <= 0;
      x_in_pos <= 1'b1;
      y_in_pos <= 1'b1;
    end else if (move_start) begin
      cnt_reg  <= DELAY;
      x_in_pos <= !move.x_move;
      y_in_pos <= !move.y_move;
    end else if (cnt_reg > 1) begin
      cnt_reg <= cnt_reg - 1;
    end else if (cnt_reg == 1) begin
      cnt_reg  <= 0;
      x_in_pos <= 1'b1;
      y_in_pos <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the motion program interpreter
// Assumes: Blocks offered only while the interpreter reports ready
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mpi_pkg::*;
  localparam int AX_DELAY = 6;
  logic        ref_clk = 0;
  logic        rst = 1;
  logic        blk_valid = 0;
  logic        err_clear = 0;
  mpi_block_t  blk = '0;
  logic [6:0]  prog_count = 7'h00;
  logic [31:0] pos_wr_value = 32'h0;
  logic [6:0]  opt = 7'h00;
  logic [7:0]  override_in = 8'h33;
  logic [7:0]  letter_char = 8'h00;
  logic        blk_ready, letter_kind_valid, move_start, x_in_pos, y_in_pos;
  logic        m_valid, is_subprogram, prog_done, err_flag;
  logic [9:0]  m_code, m_cap;
  mpi_letter_t letter_kind;
  mpi_move_t   move;
  mpi_err_t    err_code;
  int          fail_count = 0;
  int          compares = 0;
  int          ms_cnt = 0;
  logic        done_seen = 0;

  always #50 ref_clk = ~ref_clk;

  mpi_interp mpi_interp_i (.ref_clk(ref_clk), .rst(rst), .blk_valid(blk_valid), .blk(blk),
    .blk_ready(blk_ready), .prog_count(prog_count), .pos_wr_value(pos_wr_value),
    .host_opt_in(opt[4:0]), .override_in(override_in), .err_clear(err_clear),
    .gen_in(opt[6:5]), .letter_char(letter_char), .letter_kind_valid(letter_kind_valid),
    .letter_kind(letter_kind), .move(move), .move_start(move_start), .x_in_pos(x_in_pos),
    .y_in_pos(y_in_pos), .m_valid(m_valid), .m_code(m_code), .is_subprogram(is_subprogram),
    .prog_done(prog_done), .err_flag(err_flag), .err_code(err_code));

  mpi_axis_model #(.DELAY(AX_DELAY)) mpi_axis_model_i (.ref_clk(ref_clk), .rst(rst),
    .move_start(move_start), .move(move), .x_in_pos(x_in_pos), .y_in_pos(y_in_pos));

  // Pulses are caught here so a task never has to be waiting on the exact edge
  always @(posedge ref_clk) begin
    if (move_start) ms_cnt++;
    if (m_valid) m_cap = m_code;
    if (prog_done) done_seen = 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic mpi_block_t bk(input mpi_cmd_t c, input logic [31:0] v);
    bk = '0;
    bk.cmd = c;
    bk.prog_num = v[9:0];
    bk.x_arg.opnd.value = v;
  endfunction

  task automatic rdy;
    int n = 0;
    while (blk_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chk(blk_ready, 1);
  endtask

  task automatic send(input mpi_block_t b);
    rdy();
    blk = b;
    blk_valid = 1;
    @(negedge ref_clk);
    blk_valid = 0;
  endtask

  task automatic run(input mpi_block_t b);
    send(b);
    rdy();
    chk(err_flag, 0);
  endtask

  task automatic err(input mpi_block_t b, input mpi_err_t e);
    send(b);
    repeat (12) @(negedge ref_clk);
    chk(err_flag, 1);
    chk(err_code, e);
    err_clear = 1;
    @(negedge ref_clk);
    err_clear = 0;
    rdy();
    chk(err_flag, 0);
  endtask

  // Waits for the start, disturbs override mid-move, times the return to idle
  task automatic fin(input int m0);
    int n = 0;
    logic [7:0] ov = override_in;
    while (ms_cnt == m0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chk(ms_cnt, m0 + 1);
    override_in = ~ov;
    n = 0;
    while (blk_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    // Axis drops at the edge after start, holds DELAY edges, then idle and ready
    chk(n, AX_DELAY + 2);
    chk(move.override, ov);
    override_in = ov;
  endtask

  task automatic mov(input mpi_block_t b);
    int m0 = ms_cnt;
    send(b);
    fin(m0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_let;
    string s = "IJRFLNP";
    for (int i = 0; i < 7; i++) begin
      letter_char = s[i];
      @(negedge ref_clk);
      chk({letter_kind_valid, letter_kind}, {1'b1, 4'(i)});
    end
    letter_char = "X";
    @(negedge ref_clk);
    chk(letter_kind, MPI_LETTER_OTHER);
  endtask

  task automatic t_decl;
    mpi_block_t b;
    prog_count = 7'h64;
    run(bk(MPI_CMD_DECLARE, 32'h1F4));
    chk(is_subprogram, 1);
    run(bk(MPI_CMD_DECLARE, 32'h1F3));
    chk(is_subprogram, 0);
    err(bk(MPI_CMD_DECLARE, 32'h3E8), MPI_ERR_PROG_NUM);
    b = bk(MPI_CMD_DECLARE, 32'h0);
    b.block_num = 10'h001;
    err(b, MPI_ERR_DECL_BLOCK);
    prog_count = 7'h65;
    err(bk(MPI_CMD_DECLARE, 32'h0), MPI_ERR_PROG_COUNT);
    prog_count = 7'h64;
    run(bk(MPI_CMD_DECLARE, 32'h0));
    err(bk(MPI_CMD_SUBPROGRAM_END, 32'h0), MPI_ERR_END_KIND);
    // Host side starts the main program from its first block with no mode changes here
    run(bk(MPI_CMD_DECLARE, 32'h0));
    done_seen = 0;
    run(bk(MPI_CMD_MAIN_PROGRAM_END, 32'h0));
    chk(done_seen, 1);
  endtask

  task automatic t_regs;
    mpi_block_t b;
    run(bk(MPI_CMD_VALUE_SUBSTITUTION, 32'h5));
    b = bk(MPI_CMD_VALUE_SUBSTITUTION, 32'h7CF);
    b.dst_reg = 5'h01;
    run(b);
    err(bk(MPI_CMD_VALUE_SUBSTITUTION, 32'h7D0), MPI_ERR_REG_RANGE);
    err(bk(MPI_CMD_VALUE_SUBSTITUTION, 32'h1000), MPI_ERR_REG_RANGE);
    b = bk(MPI_CMD_ARITHMETIC_OPERATION, 32'h0);
    b.dst_reg = 5'h1F;
    b.src_b_reg = 5'h01;
    err(b, MPI_ERR_REG_RANGE);
    b.sub_not_add = 1'b1;
    b.src_a_reg = 5'h01;
    b.src_b_reg = 5'h00;
    run(b);
    pos_wr_value = 32'hFD9D_A601;
    run(bk(MPI_CMD_POS_WRITE, 32'h5));
    pos_wr_value = 32'h2A;
    run(bk(MPI_CMD_POS_WRITE, 32'h7CF));
    b = bk(MPI_CMD_POINT_TO_POINT_POSITIONING, 32'h0);
    b.x_arg.used = 1'b1;
    b.x_arg.opnd.kind = MPI_OP_REG_INDIRECT;
    b.y_arg.used = 1'b1;
    b.y_arg.opnd.kind = MPI_OP_REG_DIRECT;
    b.y_arg.opnd.value = 32'h1F;
    b.m_used = 1'b1;
    b.m_opnd.kind = MPI_OP_REG_INDIRECT;
    b.m_opnd.value = 32'h1;
    mov(b);
    chk(move.x_target, 32'hFD9D_A601);
    chk(move.y_target, 32'h7CA);
    chk(m_cap, 10'h2A);
    chk({move.x_move, move.y_move}, 2'b11);
  endtask

  task automatic t_lim;
    mpi_block_t b;
    b = bk(MPI_CMD_POINT_TO_POINT_POSITIONING, 32'h0);
    b.x_arg.used = 1'b1;
    b.x_arg.ckind = MPI_COORD_PLUS_LIMIT;
    b.y_arg.used = 1'b1;
    b.y_arg.ckind = MPI_COORD_MINUS_LIMIT;
    mov(b);
    chk({move.x_kind, move.y_kind}, {MPI_COORD_PLUS_LIMIT, MPI_COORD_MINUS_LIMIT});
    b = bk(MPI_CMD_POINT_TO_POINT_POSITIONING, 32'h0262_59FF);
    b.x_arg.used = 1'b1;
    mov(b);
    chk({move.x_move, move.y_move}, 2'b10);
    chk(move.x_target, 32'h0262_59FF);
    b.x_arg.opnd.value = 32'h0262_5A00;
    err(b, MPI_ERR_POS_RANGE);
    b.x_arg.opnd.value = 32'hFD9D_A600;
    err(b, MPI_ERR_POS_RANGE);
    b.x_arg.opnd.value = 32'h0;
    b.m_used = 1'b1;
    b.m_opnd.value = 32'h3E8;
    err(b, MPI_ERR_MCODE);
    b.m_used = 1'b0;
    b.opt_used = 1'b1;
    b.opt_num = 3'h7;
    err(b, MPI_ERR_OPT);
    for (int i = 0; i < 7; i++) begin
      int m0 = ms_cnt;
      b.opt_num = 3'(i);
      opt = 7'h00;
      send(b);
      repeat (15) @(negedge ref_clk);
      chk(ms_cnt, m0);
      opt = 7'h01 << i;
      fin(m0);
    end
  endtask

  task automatic t_rst;
    mpi_block_t b;
    rst = 1;
    repeat (6) @(negedge ref_clk);
    rst = 0;
    b = bk(MPI_CMD_POINT_TO_POINT_POSITIONING, 32'h7CF);
    b.x_arg.used = 1'b1;
    b.x_arg.opnd.kind = MPI_OP_POS_ADDR;
    b.y_arg.used = 1'b1;
    b.y_arg.opnd.kind = MPI_OP_REG_DIRECT;
    b.y_arg.opnd.value = 32'h1F;
    mov(b);
    chk(move.y_target, 32'h0);
    chk(move.x_target, 32'h2A);
  endtask

  task automatic give_verdict;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 0;
    t_let();
    t_decl();
    t_regs();
    t_lim();
    t_rst();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
